/* core/hul_pkg.sv */
package hul_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned POR_MS       = 2;
   localparam int unsigned POR_MAX_MS   = 8;
   localparam int unsigned NRDY_MS      = 2;
   localparam int unsigned NRDY_MIN_MS  = 1;
   localparam int unsigned NRDY_MAX_MS  = 10;
   localparam int unsigned POR_CYC      = POR_MS * (CLK_HZ / 1000);
   localparam int unsigned NRDY_CYC     = NRDY_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W        = 24;

   // ==========================================================
   // Serial format and rates
   localparam int unsigned OVS          = 16;
   localparam int unsigned DATA_BITS    = 8;
   localparam int unsigned STOP_BITS    = 1;
   localparam int unsigned BAUD_DEF     = 115_200;
   localparam int unsigned BAUD_MIN     = 1_200;
   localparam int unsigned BAUD_MAX     = 921_600;
   localparam int unsigned DIV_W        = 16;
   localparam logic [15:0] DIV_RST      = 16'(CLK_HZ / (OVS * BAUD_DEF));
   localparam logic [15:0] DIV_LO       = 16'(CLK_HZ / (OVS * BAUD_MAX));
   localparam logic [15:0] DIV_HI       = 16'(CLK_HZ / (OVS * BAUD_MIN));
   localparam logic [3:0]  PH_MID       = 4'h7;
   localparam logic [3:0]  PH_LAST      = 4'hF;
   localparam logic [3:0]  BIT_STOP     = 4'(DATA_BITS + 1);
   localparam logic        FLOW_RST     = 1'b0;

   // ==========================================================
   // Register map (byte addresses) and fields
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_BAUD    = 8'h04;
   localparam logic [7:0]  ADDR_STAT    = 8'h08;
   localparam logic [7:0]  ADDR_TXD     = 8'h0C;
   localparam logic [7:0]  ADDR_RXD     = 8'h10;
   localparam int unsigned CTRL_FLOW    = 0;
   localparam int unsigned ST_READY     = 0;
   localparam int unsigned ST_TX_BUSY   = 1;
   localparam int unsigned ST_RX_VALID  = 2;
   localparam int unsigned ST_OVERRUN   = 3;
   localparam int unsigned ST_FRAME_ERR = 4;
   localparam int unsigned ST_ENABLED   = 5;
   localparam int unsigned ST_RADIO_ON  = 6;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      PW_POR,
      PW_OFF,
      PW_RADIO,
      PW_INIT,
      PW_NRDY,
      PW_READY
   } hul_pwr_t;

   typedef struct packed {
      logic        flow_en;
      logic [15:0] div;
   } hul_cfg_t;

endpackage

/* core/hul_baud_gen.sv */
`timescale 1ns/1ns
`default_nettype none

// Oversampling tick: one-cycle enable every div_i clocks while run_i is high
module hul_baud_gen #(
   parameter int unsigned W = 16
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         run_i,
   input  wire logic [W-1:0] div_i,
   output logic              tick_o
);

   logic [W-1:0] cnt_q;

   // ==========================================================
   // Divider
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q  <= '0;
         tick_o <= 1'b0;
      end else if (!run_i) begin
         cnt_q  <= '0;
         tick_o <= 1'b0;
      end else if (cnt_q >= div_i - W'(1)) begin
         cnt_q  <= '0;
         tick_o <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + W'(1);
         tick_o <= 1'b0;
      end
   end

endmodule // hul_baud_gen

`default_nettype wire

/* core/hul_link.sv */
`timescale 1ns/1ns
`default_nettype none

module hul_link #(
   parameter int unsigned POR_CYCLES  = hul_pkg::POR_CYC,
   parameter int unsigned NRDY_CYCLES = hul_pkg::NRDY_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        module_enable_in_i,
   input  wire logic        rx_i,
   input  wire logic        cts_n_i,
   output logic             tx_o,
   output logic             rts_n_o
);

   // ==========================================================
   // Pin synchronisers
   logic [1:0] en_sy_q;
   logic [1:0] rx_sy_q;
   logic [1:0] cts_sy_q;
   logic       en_s;
   logic       rx_s;
   logic       cts_n_s;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_sy_q  <= 2'h0;
         rx_sy_q  <= 2'h3;
         cts_sy_q <= 2'h3;
      end else begin
         en_sy_q  <= {en_sy_q[0], module_enable_in_i};
         rx_sy_q  <= {rx_sy_q[0], rx_i};
         cts_sy_q <= {cts_sy_q[0], cts_n_i};
      end
   end

   assign en_s    = en_sy_q[1];
   assign rx_s    = rx_sy_q[1];
   assign cts_n_s = cts_sy_q[1];

   // ==========================================================
   // Power-on sequence
   hul_pkg::hul_pwr_t         pwr_q;
   logic [hul_pkg::CNT_W-1:0] pcnt_q;
   logic                      ready;
   logic                      radio_on;

   assign ready    = (pwr_q == hul_pkg::PW_READY);
   assign radio_on = (pwr_q != hul_pkg::PW_POR) && (pwr_q != hul_pkg::PW_OFF);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_q  <= hul_pkg::PW_POR;
         pcnt_q <= '0;
      end else begin
         unique case (pwr_q)
            hul_pkg::PW_POR: begin
               // Internal reset holds until the supplies are assumed settled
               if (pcnt_q >= hul_pkg::CNT_W'(POR_CYCLES - 1)) begin
                  pwr_q  <= hul_pkg::PW_OFF;
                  pcnt_q <= '0;
               end else begin
                  pcnt_q <= pcnt_q + hul_pkg::CNT_W'(1);
               end
            end
            hul_pkg::PW_OFF: begin
               if (en_s) begin
                  pwr_q <= hul_pkg::PW_RADIO;
               end
            end
            hul_pkg::PW_RADIO: begin
               pwr_q <= en_s ? hul_pkg::PW_INIT : hul_pkg::PW_OFF;
            end
            hul_pkg::PW_INIT: begin
               pwr_q  <= en_s ? hul_pkg::PW_NRDY : hul_pkg::PW_OFF;
               pcnt_q <= '0;
            end
            hul_pkg::PW_NRDY: begin
               if (!en_s) begin
                  pwr_q <= hul_pkg::PW_OFF;
               end else if (pcnt_q >= hul_pkg::CNT_W'(NRDY_CYCLES - 1)) begin
                  pwr_q <= hul_pkg::PW_READY;
               end else begin
                  pcnt_q <= pcnt_q + hul_pkg::CNT_W'(1);
               end
            end
            hul_pkg::PW_READY: begin
               if (!en_s) begin
                  pwr_q <= hul_pkg::PW_OFF;
               end
            end
            default: begin
               pwr_q <= hul_pkg::PW_OFF;
            end
         endcase
      end
   end

   // ==========================================================
   // APB slave: one wait state, answer on the second access cycle
   hul_pkg::hul_cfg_t cfg_q;
   logic              acc;
   logic              wr_done;
   logic              rd_done;
   logic              tx_busy_q;
   logic              rx_valid_q;
   logic              ovr_q;
   logic              ferr_q;
   logic [7:0]        rx_data_q;
   logic [15:0]       div_w;
   logic [31:0]       rd_mux;
   logic              err_mux;

   assign acc     = psel_i & penable_i & pready_o;
   assign wr_done = acc & pwrite_i;
   assign rd_done = acc & ~pwrite_i;

   always_comb begin
      rd_mux  = 32'h0000_0000;
      err_mux = 1'b0;
      unique case (paddr_i)
         hul_pkg::ADDR_CTRL: rd_mux[hul_pkg::CTRL_FLOW] = cfg_q.flow_en;
         hul_pkg::ADDR_BAUD: rd_mux[15:0] = cfg_q.div;
         hul_pkg::ADDR_STAT: begin
            rd_mux[hul_pkg::ST_READY]     = ready;
            rd_mux[hul_pkg::ST_TX_BUSY]   = tx_busy_q;
            rd_mux[hul_pkg::ST_RX_VALID]  = rx_valid_q;
            rd_mux[hul_pkg::ST_OVERRUN]   = ovr_q;
            rd_mux[hul_pkg::ST_FRAME_ERR] = ferr_q;
            rd_mux[hul_pkg::ST_ENABLED]   = en_s;
            rd_mux[hul_pkg::ST_RADIO_ON]  = radio_on;
         end
         // Refused while busy or not ready: software must poll status first
         hul_pkg::ADDR_TXD: err_mux = pwrite_i & (tx_busy_q | ~ready);
         hul_pkg::ADDR_RXD: rd_mux[7:0] = rx_data_q;
         default:           err_mux = 1'b1;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & err_mux;
         if (psel_i & penable_i & ~pready_o & ~pwrite_i) begin
            prdata_o <= rd_mux;
         end
      end
   end

   // Out-of-range divisors are clamped to the supported rate band
   always_comb begin
      if (pwdata_i[15:0] < hul_pkg::DIV_LO) begin
         div_w = hul_pkg::DIV_LO;
      end else if (pwdata_i[15:0] > hul_pkg::DIV_HI) begin
         div_w = hul_pkg::DIV_HI;
      end else begin
         div_w = pwdata_i[15:0];
      end
   end

   // Initialisation restores the documented defaults on every start-up
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_q.flow_en <= hul_pkg::FLOW_RST;
         cfg_q.div     <= hul_pkg::DIV_RST;
      end else if (pwr_q == hul_pkg::PW_INIT) begin
         cfg_q.flow_en <= hul_pkg::FLOW_RST;
         cfg_q.div     <= hul_pkg::DIV_RST;
      end else if (wr_done && paddr_i == hul_pkg::ADDR_CTRL) begin
         cfg_q.flow_en <= pwdata_i[hul_pkg::CTRL_FLOW];
      end else if (wr_done && paddr_i == hul_pkg::ADDR_BAUD) begin
         cfg_q.div <= div_w;
      end
   end

   // ==========================================================
   // Shared oversampling tick
   logic tick;

   hul_baud_gen #(
      .W (hul_pkg::DIV_W)
   ) u_baud (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .run_i   (ready),
      .div_i   (cfg_q.div),
      .tick_o  (tick)
   );

   // ==========================================================
   // Transmitter, fixed 8N1, LSB first
   logic       tx_act_q;
   logic [9:0] tx_sh_q;
   logic [3:0] tx_ph_q;
   logic [3:0] tx_bit_q;
   logic       tx_push;

   assign tx_push = wr_done & (paddr_i == hul_pkg::ADDR_TXD) & ~pslverr_o;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_busy_q <= 1'b0;
         tx_act_q  <= 1'b0;
         tx_sh_q   <= 10'h3FF;
         tx_ph_q   <= 4'h0;
         tx_bit_q  <= 4'h0;
         tx_o      <= 1'b1;
      end else if (!ready) begin
         tx_busy_q <= 1'b0;
         tx_act_q  <= 1'b0;
         tx_o      <= 1'b1;
      end else if (tx_push) begin
         tx_busy_q <= 1'b1;
         tx_sh_q   <= {1'b1, pwdata_i[7:0], 1'b0};
      end else if (tx_busy_q && !tx_act_q) begin
         // With flow control on, held until the host's clear-to-send is low
         if (tick && (!cfg_q.flow_en || !cts_n_s)) begin
            tx_act_q <= 1'b1;
            tx_ph_q  <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_o     <= tx_sh_q[0];
         end
      end else if (tx_act_q && tick) begin
         tx_ph_q <= tx_ph_q + 4'h1;
         if (tx_ph_q == hul_pkg::PH_LAST) begin
            if (tx_bit_q == hul_pkg::BIT_STOP) begin
               tx_busy_q <= 1'b0;
               tx_act_q  <= 1'b0;
            end else begin
               tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
               tx_o     <= tx_sh_q[1];
               tx_bit_q <= tx_bit_q + 4'h1;
            end
         end
      end
   end

   // ==========================================================
   // Receiver, samples mid-bit on the oversampling tick
   logic       rx_act_q;
   logic [3:0] rx_ph_q;
   logic [3:0] rx_bit_q;
   logic [7:0] rx_sh_q;
   logic       rx_done;
   logic       rx_take;
   logic       stat_wr;

   assign rx_done = rx_act_q & tick & (rx_ph_q == hul_pkg::PH_MID) &
                    (rx_bit_q == hul_pkg::BIT_STOP);
   assign rx_take = rd_done & (paddr_i == hul_pkg::ADDR_RXD);
   assign stat_wr = wr_done & (paddr_i == hul_pkg::ADDR_STAT);

   // Traffic arriving before the ready state is dropped, not queued
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_act_q <= 1'b0;
         rx_ph_q  <= 4'h0;
         rx_bit_q <= 4'h0;
         rx_sh_q  <= 8'h00;
      end else if (!ready) begin
         rx_act_q <= 1'b0;
      end else if (!rx_act_q) begin
         if (tick && !rx_s) begin
            rx_act_q <= 1'b1;
            rx_ph_q  <= 4'h0;
            rx_bit_q <= 4'h0;
         end
      end else if (tick) begin
         rx_ph_q <= rx_ph_q + 4'h1;
         if (rx_ph_q == hul_pkg::PH_MID) begin
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0 && rx_s) begin
               rx_act_q <= 1'b0; // Glitch, not a start bit
            end else if (rx_bit_q == hul_pkg::BIT_STOP) begin
               rx_act_q <= 1'b0;
            end else if (rx_bit_q != 4'h0) begin
               rx_sh_q <= {rx_s, rx_sh_q[7:1]};
            end
         end
      end
   end

   // Hardware set wins over a same-cycle software clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_valid_q <= 1'b0;
         rx_data_q  <= 8'h00;
         ovr_q      <= 1'b0;
         ferr_q     <= 1'b0;
      end else if (!ready) begin
         rx_valid_q <= 1'b0;
      end else begin
         rx_valid_q <= (rx_done & rx_s) | (rx_valid_q & ~rx_take);
         if (rx_done && rx_s) begin
            rx_data_q <= rx_sh_q;
         end
         ovr_q  <= (rx_done & rx_s & rx_valid_q & ~rx_take) |
                   (ovr_q & ~(stat_wr & pwdata_i[hul_pkg::ST_OVERRUN]));
         ferr_q <= (rx_done & ~rx_s) |
                   (ferr_q & ~(stat_wr & pwdata_i[hul_pkg::ST_FRAME_ERR]));
      end
   end

   // ==========================================================
   // Request-to-send: low only when ready and the holding byte is free
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rts_n_o <= 1'b1;
      end else begin
         rts_n_o <= ~(cfg_q.flow_en & ready & ~rx_valid_q);
      end
   end

endmodule // hul_link

`default_nettype wire

/* tb/hul_link_sva.sv */
`timescale 1ns/1ns
`default_nettype none

module hul_link_sva #(
   parameter int unsigned POR_CYCLES  = 50,
   parameter int unsigned NRDY_CYCLES = 80
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        module_enable_in_i,
   input wire logic        rx_i,
   input wire logic        cts_n_i,
   input wire logic        tx_o,
   input wire logic        rts_n_o
);
   int unsigned cnt_q;
   logic [3:0]  en_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // =========================================================
   // Cycles since reset: a lower bound for any start-up
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 32'h0;
      end else if (cnt_q < POR_CYCLES + NRDY_CYCLES) begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   // Enable history: a legal disable may cut a frame short, so bit checks pause
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_q <= 4'h0;
      end else begin
         en_q <= {en_q[2:0], module_enable_in_i};
      end
   end

   // =========================================================
   // Properties
   a_ready_timing: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready held longer than one cycle");
   a_rdata_hold: assert property (!$stable(prdata_o) |-> pready_o && !pwrite_i)
      else $error("read data changed outside a read");
   a_upper_zero: assert property (pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0)
      else $error("upper read data bits not zero");
   a_unmapped_err: assert property (pready_o && paddr_i > 8'h10 |-> pslverr_o)
      else $error("unmapped access without error");
   a_unmapped_zero: assert property (pready_o && !pwrite_i && paddr_i > 8'h10 |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_off_idle: assert property (!module_enable_in_i [*6] |-> tx_o && rts_n_o)
      else $error("serial pins active while disabled");
   a_rts_early: assert property (cnt_q < POR_CYCLES + NRDY_CYCLES |-> rts_n_o)
      else $error("rts low before not-ready interval ended");
   a_push_early: assert property (pready_o && pwrite_i && paddr_i == 8'h0C &&
      cnt_q < POR_CYCLES + NRDY_CYCLES |-> pslverr_o)
      else $error("transmit byte taken before ready");
   a_bit_width: assert property (
      disable iff (!rst_n_i || !module_enable_in_i || en_q != 4'hF)
      $fell(tx_o) |=> !tx_o [*8])
      else $error("low serial bit too short");
endmodule // hul_link_sva

bind hul_link hul_link_sva #(.POR_CYCLES(POR_CYCLES), .NRDY_CYCLES(NRDY_CYCLES)) u_sva (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .module_enable_in_i(module_enable_in_i),
   .rx_i(rx_i), .cts_n_i(cts_n_i), .tx_o(tx_o), .rts_n_o(rts_n_o));

`default_nettype wire

/* tb/hul_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Host end of the serial link; its line idles high as a real UART does
module hul_host_model #(
   parameter int BIT_CLKS = 48
) (
   input  wire logic clk_i,
   input  wire logic tx_i,
   output var logic  rx_o,
   output var logic  cts_n_o
);
   initial begin
      rx_o = 1'b1;
      cts_n_o = 1'b0;
   end

   task automatic set_cts(input logic v);
      @(posedge clk_i);
      cts_n_o <= v;
   endtask

   // Stop level is a task argument so a broken frame can be sent on purpose
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i);
         rx_o <= f[i];
         repeat (BIT_CLKS - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      rx_o <= 1'b1;
   endtask

   task automatic recv(output logic [7:0] b, output logic stop);
      // Ends on the start bit; if none comes, only the bench watchdog ends this wait
      while (tx_i !== 1'b0) begin
         @(posedge clk_i);
      end
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk_i);
         b[i] = tx_i;
      end
      repeat (BIT_CLKS) @(posedge clk_i);
      stop = tx_i;
   endtask
endmodule // hul_host_model

`default_nettype wire

/* tb/tb_hul_link.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_hul_link;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] r;
      logic        e;
   } hul_row_t;

   localparam int DIVF = 3;
   localparam int NRDY = 80;
   // Clamp rows run before enable, so start-up must restore the defaults
   localparam hul_row_t ROWS [12] = '{
      '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h1B, 1'b0},
      '{1'b1, 8'h04, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h3, 1'b0},
      '{1'b1, 8'h04, 32'hFFFF, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'hA2C, 1'b0},
      '{1'b1, 8'h14, 32'h1, 32'h0, 1'b1},
      '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
      '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
      '{1'b1, 8'h0C, 32'h55, 32'h0, 1'b1},
      '{1'b1, 8'h00, 32'h1, 32'h0, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h1, 1'b0}
   };

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic        en = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx;
   logic        cts_n;
   logic        tx;
   logic        rts_n;
   logic [31:0] r;
   logic        e;
   logic [7:0]  b;
   logic        s;
   int          mismatches = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          t0;

   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   hul_link #(.POR_CYCLES(50), .NRDY_CYCLES(NRDY)) u_dut (
      .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .module_enable_in_i(en),
      .rx_i(rx), .cts_n_i(cts_n), .tx_o(tx), .rts_n_o(rts_n));

   hul_host_model #(.BIT_CLKS(16 * DIVF)) u_host (
      .clk_i(clk), .tx_i(tx), .rx_o(rx), .cts_n_o(cts_n));

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         $display("[FAIL] %s expected %h seen %h", n, x, g);
         mismatches++;
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready wait", 32'h2, 32'(n));
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      chk("tx idle", 32'h1, 32'(tx));
      chk("rts idle", 32'h1, 32'(rts_n));
      for (int i = 0; i < 12; i++) begin
         apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
         chk("error", 32'(ROWS[i].e), 32'(e));
         if (!ROWS[i].w) chk("rdata", ROWS[i].r, r);
      end
      $display("test registers done");
      t0 = cyc;
      en <= 1'b1;
      apb(1'b0, 8'h08, 32'h0);
      chk("not ready", 32'h0, 32'(r[0]));
      for (int k = 0; k < 100 && r[0] !== 1'b1; k++) apb(1'b0, 8'h08, 32'h0);
      chk("ready window", 32'h1, 32'(cyc - t0 >= NRDY && cyc - t0 < 300));
      apb(1'b0, 8'h04, 32'h0);
      chk("baud reload", 32'h1B, r);
      apb(1'b0, 8'h00, 32'h0);
      chk("flow off", 32'h0, r);
      chk("rts flow off", 32'h1, 32'(rts_n));
      apb(1'b1, 8'h04, 32'(DIVF));
      apb(1'b1, 8'h00, 32'h1);
      repeat (4) @(posedge clk);
      chk("rts ready", 32'h0, 32'(rts_n));
      $display("test start-up done");
      u_host.send(8'hA5, 1'b1);
      chk("rts held", 32'h1, 32'(rts_n));
      apb(1'b0, 8'h10, 32'h0);
      chk("rx byte", 32'hA5, r);
      repeat (4) @(posedge clk);
      chk("rts again", 32'h0, 32'(rts_n));
      u_host.send(8'h0F, 1'b0);
      apb(1'b0, 8'h08, 32'h0);
      chk("frame error", 32'h1, 32'(r[4]));
      apb(1'b1, 8'h08, 32'h10);
      apb(1'b0, 8'h08, 32'h0);
      chk("frame clear", 32'h0, 32'(r[4]));
      // Flow control off: transmit ignores clear-to-send, host ignores request-to-send
      apb(1'b1, 8'h00, 32'h0);
      u_host.set_cts(1'b1);
      apb(1'b1, 8'h0C, 32'h5A);
      chk("tx push free", 32'h0, 32'(e));
      u_host.recv(b, s);
      chk("tx no flow", 32'h5A, 32'(b));
      u_host.send(8'h11, 1'b1);
      u_host.send(8'h22, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      chk("overrun", 32'h1, 32'(r[3]));
      apb(1'b0, 8'h10, 32'h0);
      chk("rx overwrite", 32'h22, r);
      apb(1'b1, 8'h00, 32'h1);
      $display("test receive done");
      repeat (100) @(posedge clk);
      u_host.set_cts(1'b1);
      apb(1'b1, 8'h0C, 32'h3C);
      chk("tx push", 32'h0, 32'(e));
      apb(1'b1, 8'h0C, 32'h77);
      chk("tx busy", 32'h1, 32'(e));
      repeat (200) @(posedge clk);
      chk("cts holds tx", 32'h1, 32'(tx));
      u_host.set_cts(1'b0);
      u_host.recv(b, s);
      chk("tx byte", 32'h3C, 32'(b));
      chk("tx stop", 32'h1, 32'(s));
      $display("test transmit done");
      en <= 1'b0;
      repeat (8) @(posedge clk);
      chk("off rts", 32'h1, 32'(rts_n));
      u_host.send(8'h11, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      chk("off status", 32'h0, r & 32'h25);
      $display("test disable done");
      // Reset pulse stands in for the supply off interval before power-up
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      chk("reset tx", 32'h1, 32'(tx));
      chk("reset rts", 32'h1, 32'(rts_n));
      apb(1'b0, 8'h04, 32'h0);
      chk("reset baud", 32'h1B, r);
      apb(1'b0, 8'h00, 32'h0);
      chk("reset flow", 32'h0, r);
      $display("test reset done");
      finish_test;
   end

   // Whole run is a few thousand cycles; this margin only trips on a hang
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      finish_test;
   end
endmodule // tb_hul_link

`default_nettype wire
